// file: mte_table_access.sv
// Entry registers, indirect access sequencing and DA/SA lookup of the tables.
//
// Contract
// - Word1 bit31 set means static, never aged.
// - Source filter bit drops matching source packets.
// - Destination filter bit drops matching destination packets.
// - Bits 28:26 are priority or age count.
// - Bits 2:0 hold spanning group identifier.
// - Word2 bit31 lets forwarding bypass port state.
// - Word2 bits 6:0 are port forward mask.
// - Word3 group and MAC high, word4 MAC low.
// - Separate sixteen-entry static table, never aged.
// - Destination lookup searches every address table.
// - Static hits beat dynamic hits.
// - Device clears go_done flag on completion.
// - Static table word1 bit31 is valid flag.
// - Main table accepts only static entry writes.
`timescale 1ns/100ps
`include "mte_table_regs.svh"

module mte_table_access #(
  parameter int DEPTH = 4096,
  parameter int IDX_W = 12
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        age_tick,
  input  wire logic        da_req,
  input  wire logic [47:0] da_mac,
  input  wire logic [6:0]  da_fid,
  input  wire logic        sa_req,
  input  wire logic [47:0] sa_mac,
  input  wire logic [6:0]  sa_fid,
  output logic             da_valid,
  output logic             da_hit,
  output logic             da_static,
  output logic             da_drop,
  output logic      [6:0]  da_fwd,
  output logic             da_bypass,
  output logic      [2:0]  da_pri,
  output logic      [2:0]  da_spanning_group_id,
  output logic             sa_valid,
  output logic             sa_drop
);

  // ========================================================================
  // Helpers
  function automatic logic ok_f(input logic [31:0] w1);
    ok_f = w1[`MTE_W1_STATIC] ||
           (w1[`MTE_W1_AGE_HI:`MTE_W1_AGE_LO] != 3'h0);
  endfunction : ok_f

  function automatic logic key_f(input logic [31:0] w3, input logic [31:0] w4,
                                 input logic [47:0] mac, input logic [6:0] vlan_filter_group);
    key_f = ({w3[`MTE_W3_MAC_HI:`MTE_W3_MAC_LO], w4} == mac) &&
            (w3[`MTE_W3_FID_HI:`MTE_W3_FID_LO] == vlan_filter_group);
  endfunction : key_f

  // ========================================================================
  // State
  mte_table_pkg::mte_state_t state_q;
  logic [31:0]      mw1_q [DEPTH];
  logic [31:0]      mw2_q [DEPTH];
  logic [31:0]      mw3_q [DEPTH];
  logic [31:0]      mw4_q [DEPTH];
  logic [31:0]      dw1_q, dw2_q, dw3_q, dw4_q;
  logic [3:0]       sidx_q;
  logic             stsel_q, sact_q, sgo_q, last_st_q;
  logic [IDX_W-1:0] midx_q, ptr_q;
  logic [1:0]       mact_q;
  logic             mgo_q, mvalid_q;

  // ========================================================================
  // Register decode
  wire hit_w1 = reg_addr == `MTE_ENTRY1_ADDR;
  wire hit_w2 = reg_addr == `MTE_ENTRY2_ADDR;
  wire hit_w3 = reg_addr == `MTE_ENTRY3_ADDR;
  wire hit_w4 = reg_addr == `MTE_ENTRY4_ADDR;
  wire hit_sc = reg_addr == `MTE_SCTRL_ADDR;
  wire hit_mc = reg_addr == `MTE_MCTRL_ADDR;
  wire sc_wr  = reg_wr && hit_sc;
  wire mc_wr  = reg_wr && hit_mc;
  wire idle   = state_q == mte_table_pkg::MTE_IDLE;

  wire [31:0] sc_rd = {23'h000000, last_st_q, sgo_q, 1'b0, sact_q, stsel_q,
                       sidx_q};
  wire [31:0] mc_rd = {15'h0000, mvalid_q, mgo_q, 1'b0, mact_q,
                       (12)'(midx_q)};
  wire [31:0] rd_mux = hit_w1 ? dw1_q : hit_w2 ? dw2_q : hit_w3 ? dw3_q :
                       hit_w4 ? dw4_q : hit_sc ? sc_rd : hit_mc ? mc_rd :
                       32'h00000000;

  // ========================================================================
  // Operations started by the go_done flags
  wire s_op   = idle && sgo_q && !stsel_q;
  wire s_wr   = s_op && !sact_q;
  wire s_rd   = s_op && sact_q;
  wire m_op   = idle && mgo_q;
  wire m_rd   = m_op && mact_q == `MTE_ACT_READ;
  wire m_wr   = m_op && mact_q == `MTE_ACT_WRITE &&
                dw1_q[`MTE_W1_STATIC];
  wire m_sr   = m_op && mact_q == `MTE_ACT_SEARCH;
  wire pt_ok  = ok_f(mw1_q[ptr_q]);
  wire pt_end = ptr_q == IDX_W'(DEPTH - 1);
  wire m_stop = mc_wr && !reg_wdata[`MTE_MC_GO];
  wire w4_rd  = reg_rd && hit_w4;
  wire [31:0] mrd1 = ok_f(mw1_q[midx_q]) ? mw1_q[midx_q] : 32'h00000000;

  // ========================================================================
  // Lookups in the main table
  logic             m_st_hit, m_dy_hit, sam_hit;
  logic [IDX_W-1:0] m_st_idx, m_dy_idx, sam_idx;
  always_comb begin
    m_st_hit = 1'b0;
    m_dy_hit = 1'b0;
    sam_hit  = 1'b0;
    m_st_idx = '0;
    m_dy_idx = '0;
    sam_idx  = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (ok_f(mw1_q[i]) && key_f(mw3_q[i], mw4_q[i], da_mac, da_fid)) begin
        if (mw1_q[i][`MTE_W1_STATIC]) begin
          m_st_hit = 1'b1;
          m_st_idx = IDX_W'(i);
        end else begin
          m_dy_hit = 1'b1;
          m_dy_idx = IDX_W'(i);
        end
      end
      if (ok_f(mw1_q[i]) && key_f(mw3_q[i], mw4_q[i], sa_mac, sa_fid)) begin
        sam_hit = 1'b1;
        sam_idx = IDX_W'(i);
      end
    end
  end

  logic [31:0] s_rd1, s_rd2, s_rd3, s_rd4, s_da1, s_da2, s_sa1;
  logic        s_da_hit, s_sa_hit;

  mte_static_table #(.N(16), .IDX_W(4)) u_static (
    .core_clk (core_clk),
    .reset    (reset),
    .wr_en    (s_wr),
    .wr_idx   (sidx_q),
    .wr_w1    (dw1_q),
    .wr_w2    (dw2_q),
    .wr_w3    (dw3_q),
    .wr_w4    (dw4_q),
    .rd_idx   (sidx_q),
    .rd_w1    (s_rd1),
    .rd_w2    (s_rd2),
    .rd_w3    (s_rd3),
    .rd_w4    (s_rd4),
    .da_mac   (da_mac),
    .da_fid   (da_fid),
    .da_hit   (s_da_hit),
    .da_w1    (s_da1),
    .da_w2    (s_da2),
    .sa_mac   (sa_mac),
    .sa_fid   (sa_fid),
    .sa_hit   (s_sa_hit),
    .sa_w1    (s_sa1)
  );

  // Static table first, then static main entries, then dynamic ones.
  wire        any_hit = s_da_hit || m_st_hit || m_dy_hit;
  wire [31:0] sel1 = s_da_hit ? s_da1 : m_st_hit ? mw1_q[m_st_idx] :
                     mw1_q[m_dy_idx];
  wire [31:0] sel2 = s_da_hit ? s_da2 : m_st_hit ? mw2_q[m_st_idx] :
                     mw2_q[m_dy_idx];
  wire        dy_sel = !s_da_hit && !m_st_hit && m_dy_hit;
  wire        sa_d = (s_sa_hit && s_sa1[`MTE_W1_SRCF]) ||
                     (sam_hit && mw1_q[sam_idx][`MTE_W1_SRCF]);

  // ========================================================================
  // Main table storage with aging
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (reset) begin
        mw1_q[i] <= 32'h00000000;
        mw2_q[i] <= 32'h00000000;
        mw3_q[i] <= 32'h00000000;
        mw4_q[i] <= 32'h00000000;
      end else if (m_wr && midx_q == IDX_W'(i)) begin
        mw1_q[i] <= dw1_q;
        mw2_q[i] <= dw2_q;
        mw3_q[i] <= dw3_q;
        mw4_q[i] <= dw4_q;
      end else if (!mw1_q[i][`MTE_W1_STATIC]) begin
        if ((da_req && dy_sel && m_dy_idx == IDX_W'(i)) ||
            (sa_req && sam_hit && sam_idx == IDX_W'(i))) begin
          mw1_q[i][`MTE_W1_AGE_HI:`MTE_W1_AGE_LO] <=
            `MTE_AGE_RELOAD;
        end else if (age_tick &&
                     mw1_q[i][`MTE_W1_AGE_HI:`MTE_W1_AGE_LO] != 3'h0) begin
          mw1_q[i][`MTE_W1_AGE_HI:`MTE_W1_AGE_LO] <=
            mw1_q[i][`MTE_W1_AGE_HI:`MTE_W1_AGE_LO] - 3'h1;
        end
      end
    end
  end

  // ========================================================================
  // Shared data words; masks keep reserved bits at zero.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dw1_q <= 32'h00000000;
      dw2_q <= 32'h00000000;
      dw3_q <= 32'h00000000;
      dw4_q <= 32'h00000000;
    end else if (s_rd) begin
      dw1_q <= s_rd1;
      dw2_q <= s_rd2;
      dw3_q <= s_rd3;
      dw4_q <= s_rd4;
    end else if (m_rd) begin
      dw1_q <= mrd1;
      dw2_q <= ok_f(mw1_q[midx_q]) ? mw2_q[midx_q] : 32'h00000000;
      dw3_q <= ok_f(mw1_q[midx_q]) ? mw3_q[midx_q] : 32'h00000000;
      dw4_q <= ok_f(mw1_q[midx_q]) ? mw4_q[midx_q] : 32'h00000000;
    end else if (state_q == mte_table_pkg::MTE_SCAN) begin
      dw1_q <= pt_ok ? mw1_q[ptr_q] : 32'h00000000;
      dw2_q <= pt_ok ? mw2_q[ptr_q] : 32'h00000000;
      dw3_q <= pt_ok ? mw3_q[ptr_q] : 32'h00000000;
      dw4_q <= pt_ok ? mw4_q[ptr_q] : 32'h00000000;
    end else if (reg_wr) begin
      if (hit_w1) dw1_q <= reg_wdata & `MTE_W1_MASK;
      if (hit_w2) dw2_q <= reg_wdata & `MTE_W2_MASK;
      if (hit_w3) dw3_q <= reg_wdata & `MTE_W3_MASK;
      if (hit_w4) dw4_q <= reg_wdata & `MTE_W4_MASK;
    end
  end

  // ========================================================================
  // Static control; host writes are ignored while either go_done flag is set.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sidx_q    <= 4'h0;
      stsel_q   <= 1'b0;
      sact_q    <= 1'b0;
      sgo_q     <= 1'b0;
      last_st_q <= 1'b0;
    end else begin
      if (sc_wr && idle && !sgo_q && !mgo_q) begin
        sidx_q  <= reg_wdata[`MTE_SC_IDX_HI:`MTE_SC_IDX_LO];
        stsel_q <= reg_wdata[`MTE_SC_TSEL];
        sact_q  <= reg_wdata[`MTE_SC_ACT];
        sgo_q   <= reg_wdata[`MTE_SC_GO];
      end else if (idle && sgo_q) begin
        sgo_q <= 1'b0;
      end
      if (s_op) last_st_q <= 1'b1;
      else if (m_op) last_st_q <= 1'b0;
    end
  end

  // ========================================================================
  // Main control and search sequencer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q  <= mte_table_pkg::MTE_IDLE;
      midx_q   <= '0;
      ptr_q    <= '0;
      mact_q   <= 2'h0;
      mgo_q    <= 1'b0;
      mvalid_q <= 1'b0;
    end else begin
      case (state_q)
        mte_table_pkg::MTE_IDLE: begin
          if (mc_wr && !mgo_q && !sgo_q) begin
            midx_q <= reg_wdata[IDX_W-1:`MTE_MC_IDX_LO];
            mact_q <= reg_wdata[`MTE_MC_ACT_HI:`MTE_MC_ACT_LO];
            mgo_q  <= reg_wdata[`MTE_MC_GO];
          end else if (m_sr) begin
            mvalid_q <= 1'b0;
            ptr_q    <= '0;
            state_q  <= mte_table_pkg::MTE_SCAN;
          end else if (m_op) begin
            mvalid_q <= m_rd && ok_f(mw1_q[midx_q]);
            mgo_q    <= 1'b0;
          end
        end
        mte_table_pkg::MTE_SCAN: begin
          if (m_stop || (!pt_ok && pt_end)) begin
            mgo_q   <= 1'b0;
            state_q <= mte_table_pkg::MTE_IDLE;
          end else if (pt_ok) begin
            mvalid_q <= 1'b1;
            state_q  <= mte_table_pkg::MTE_HOLD;
          end else begin
            ptr_q <= ptr_q + IDX_W'(1);
          end
        end
        mte_table_pkg::MTE_HOLD: begin
          if (m_stop || (w4_rd && pt_end)) begin
            mgo_q    <= 1'b0;
            mvalid_q <= 1'b0;
            state_q  <= mte_table_pkg::MTE_IDLE;
          end else if (w4_rd) begin
            mvalid_q <= 1'b0;
            ptr_q    <= ptr_q + IDX_W'(1);
            state_q  <= mte_table_pkg::MTE_SCAN;
          end
        end
        default: state_q <= mte_table_pkg::MTE_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Registered answers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata  <= 32'h00000000;
      reg_rvalid <= 1'b0;
      da_valid   <= 1'b0;
      da_hit     <= 1'b0;
      da_static  <= 1'b0;
      da_drop    <= 1'b0;
      da_fwd     <= 7'h00;
      da_bypass  <= 1'b0;
      da_pri     <= 3'h0;
      da_spanning_group_id    <= 3'h0;
      sa_valid   <= 1'b0;
      sa_drop    <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rd_mux;
      da_valid <= da_req;
      sa_valid <= sa_req;
      if (sa_req) sa_drop <= sa_d;
      if (da_req) begin
        da_hit    <= any_hit;
        da_static <= any_hit && !dy_sel;
        da_drop   <= any_hit && sel1[`MTE_W1_DSTF];
        da_fwd    <= any_hit ? sel2[`MTE_W2_FWD_HI:`MTE_W2_FWD_LO]
                             : 7'h00;
        da_bypass <= any_hit && sel2[`MTE_W2_BYPASS];
        da_pri    <= (any_hit && !dy_sel) ?
                     sel1[`MTE_W1_AGE_HI:`MTE_W1_AGE_LO] : 3'h0;
        da_spanning_group_id   <= any_hit ?
                     sel1[`MTE_W1_SPANNING_GROUP_ID_HI:`MTE_W1_SPANNING_GROUP_ID_LO] : 3'h0;
      end
    end
  end

endmodule : mte_table_access

// file: mte_table_regs.svh
// Register offsets, field positions and masks of the lookup entry access block.
`ifndef MTE_TABLE_REGS_SVH
`define MTE_TABLE_REGS_SVH

// ==========================================================================
// Register offsets
`define MTE_ENTRY1_ADDR  16'h0420
`define MTE_ENTRY2_ADDR  16'h0424
`define MTE_ENTRY3_ADDR  16'h0428
`define MTE_ENTRY4_ADDR  16'h042C
`define MTE_SCTRL_ADDR   16'h0440
`define MTE_MCTRL_ADDR   16'h0444

// ==========================================================================
// Entry word fields
`define MTE_W1_STATIC    31
`define MTE_W1_VALID     31
`define MTE_W1_SRCF      30
`define MTE_W1_DSTF      29
`define MTE_W1_AGE_HI    28
`define MTE_W1_AGE_LO    26
`define MTE_W1_SPANNING_GROUP_ID_HI   2
`define MTE_W1_SPANNING_GROUP_ID_LO   0
`define MTE_W2_BYPASS    31
`define MTE_W2_FWD_HI    6
`define MTE_W2_FWD_LO    0
`define MTE_W3_FID_HI    22
`define MTE_W3_FID_LO    16
`define MTE_W3_MAC_HI    15
`define MTE_W3_MAC_LO    0
`define MTE_W1_MASK      32'hFC000007
`define MTE_W2_MASK      32'h8000007F
`define MTE_W3_MASK      32'h007FFFFF
`define MTE_W4_MASK      32'hFFFFFFFF

// ==========================================================================
// Static table control fields
`define MTE_SC_IDX_HI    3
`define MTE_SC_IDX_LO    0
`define MTE_SC_TSEL      4
`define MTE_SC_ACT       5
`define MTE_SC_GO        7
`define MTE_SC_LAST      8

// ==========================================================================
// Main table control fields
`define MTE_MC_IDX_LO    0
`define MTE_MC_ACT_HI    13
`define MTE_MC_ACT_LO    12
`define MTE_MC_GO        15
`define MTE_MC_VALID     16
`define MTE_ACT_WRITE    2'h1
`define MTE_ACT_READ     2'h2
`define MTE_ACT_SEARCH   2'h3
`define MTE_AGE_RELOAD   3'h7

`endif

// file: mte_table_pkg.sv
// Types shared by the lookup entry access block.
package mte_table_pkg;

  // ========================================================================
  // Access sequencer states
  typedef enum logic [2:0] {
    MTE_IDLE = 3'b001,
    MTE_SCAN = 3'b010,
    MTE_HOLD = 3'b100
  } mte_state_t;

endpackage : mte_table_pkg

// file: mte_static_table.sv
// Sixteen-entry static address table with write port and two match ports.
`timescale 1ns/100ps
`include "mte_table_regs.svh"

module mte_static_table #(
  parameter int N     = 16,
  parameter int IDX_W = 4
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [31:0]      wr_w1,
  input  wire logic [31:0]      wr_w2,
  input  wire logic [31:0]      wr_w3,
  input  wire logic [31:0]      wr_w4,
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [31:0]      rd_w1,
  output logic      [31:0]      rd_w2,
  output logic      [31:0]      rd_w3,
  output logic      [31:0]      rd_w4,
  input  wire logic [47:0]      da_mac,
  input  wire logic [6:0]       da_fid,
  output logic                  da_hit,
  output logic      [31:0]      da_w1,
  output logic      [31:0]      da_w2,
  input  wire logic [47:0]      sa_mac,
  input  wire logic [6:0]       sa_fid,
  output logic                  sa_hit,
  output logic      [31:0]      sa_w1
);

  logic [31:0] w1_q [N];
  logic [31:0] w2_q [N];
  logic [31:0] w3_q [N];
  logic [31:0] w4_q [N];

  function automatic logic hit_f(input logic [31:0] w1, input logic [31:0] w3,
                                 input logic [31:0] w4, input logic [47:0] mac,
                                 input logic [6:0] vlan_filter_group);
    hit_f = w1[`MTE_W1_VALID] &&
            ({w3[`MTE_W3_MAC_HI:`MTE_W3_MAC_LO], w4} == mac) &&
            (w3[`MTE_W3_FID_HI:`MTE_W3_FID_LO] == vlan_filter_group);
  endfunction : hit_f

  // ========================================================================
  // Storage, host programmed only and never aged.
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < N; i++) begin
      if (reset) begin
        w1_q[i] <= 32'h00000000;
        w2_q[i] <= 32'h00000000;
        w3_q[i] <= 32'h00000000;
        w4_q[i] <= 32'h00000000;
      end else if (wr_en && wr_idx == IDX_W'(i)) begin
        w1_q[i] <= wr_w1;
        w2_q[i] <= wr_w2;
        w3_q[i] <= wr_w3;
        w4_q[i] <= wr_w4;
      end
    end
  end

  assign rd_w1 = w1_q[rd_idx];
  assign rd_w2 = w2_q[rd_idx];
  assign rd_w3 = w3_q[rd_idx];
  assign rd_w4 = w4_q[rd_idx];

  // ========================================================================
  // Matching; the lowest index wins when entries duplicate.
  always_comb begin
    da_hit = 1'b0;
    da_w1  = 32'h00000000;
    da_w2  = 32'h00000000;
    sa_hit = 1'b0;
    sa_w1  = 32'h00000000;
    for (int i = N - 1; i >= 0; i--) begin
      if (hit_f(w1_q[i], w3_q[i], w4_q[i], da_mac, da_fid)) begin
        da_hit = 1'b1;
        da_w1  = w1_q[i];
        da_w2  = w2_q[i];
      end
      if (hit_f(w1_q[i], w3_q[i], w4_q[i], sa_mac, sa_fid)) begin
        sa_hit = 1'b1;
        sa_w1  = w1_q[i];
      end
    end
  end

endmodule : mte_static_table

// file: mte_table_access_asserts.sv
// Port-level assertions for the lookup entry access block.
`timescale 1ns/100ps

// ==========================================================================
// Checker
module mte_table_access_asserts (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        da_req,
  input wire logic        sa_req,
  input wire logic        da_valid,
  input wire logic        da_hit,
  input wire logic        da_static,
  input wire logic        da_drop,
  input wire logic [6:0]  da_fwd,
  input wire logic [2:0]  da_pri,
  input wire logic        sa_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered next cycle");
  a_rdata_steady: assert property (
    !reg_rd |=> !reg_rvalid && $stable(reg_rdata))
    else $error("read data moved without a read");
  a_da_answer: assert property (da_req |=> da_valid)
    else $error("lookup not answered next cycle");
  a_da_hold: assert property (
    !da_req |=> !da_valid && $stable(da_fwd) && $stable(da_hit))
    else $error("lookup result moved without a request");
  a_sa_answer: assert property (sa_req |=> sa_valid)
    else $error("source lookup not answered next cycle");
  a_miss_quiet: assert property (
    da_valid && !da_hit |-> da_fwd == 7'h00 && !da_static && !da_drop)
    else $error("miss carries forwarding data");
  a_dyn_no_pri: assert property (
    da_hit && !da_static |-> da_pri == 3'h0)
    else $error("dynamic hit shows a priority");
  a_drop_needs_hit: assert property (da_drop |-> da_hit)
    else $error("drop without a hit");

  cover property (da_valid && da_static);
  cover property (da_valid && !da_hit);
  cover property (reg_rvalid && reg_rdata[16]);
endmodule : mte_table_access_asserts

bind mte_table_access mte_table_access_asserts i_chk (
  .core_clk, .reset, .reg_rd, .reg_rdata, .reg_rvalid, .da_req, .sa_req,
  .da_valid, .da_hit, .da_static, .da_drop, .da_fwd, .da_pri, .sa_valid);

// file: testbench.sv
// Self-checking testbench of the lookup entry access block.
`timescale 1ns/100ps
`include "mte_table_regs.svh"

module testbench;
  localparam logic [127:0] SW = 128'hF4000003_80000055_0012ABCD_01234567;
  localparam logic [127:0] MW = 128'hC8000001_00000003_0012ABCD_01234567;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0;
  logic        age_tick = 1'b0;
  logic        da_req = 1'b0;
  logic        sa_req = 1'b0;
  logic [47:0] mac = 48'h0;
  logic [6:0]  vlan_filter_group = 7'h00;
  logic [31:0] reg_rdata;
  logic        reg_rvalid, da_valid, da_hit, da_static, da_drop, da_bypass;
  logic        sa_valid, sa_drop;
  logic [6:0]  da_fwd;
  logic [2:0]  da_pri, da_spanning_group_id;
  int          bad_count = 0;
  int          total_checks = 0;

  // A table of 16 keeps the search short; nothing below assumes 4096.
  mte_table_access #(.DEPTH(16), .IDX_W(4)) i_dut (
    .core_clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .age_tick, .da_req, .da_mac(mac), .da_fid(vlan_filter_group), .sa_req,
    .sa_mac(mac), .sa_fid(vlan_filter_group), .da_valid, .da_hit, .da_static, .da_drop,
    .da_fwd, .da_bypass, .da_pri, .da_spanning_group_id, .sa_valid, .sa_drop);

  always #12.5 core_clk = ~core_clk;

  // ========================================================================
  // Bus and compare tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    check({31'h0, reg_rvalid}, 32'h1);
    d = reg_rdata;
  endtask : rd

  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(d, e);
  endtask : rdc

  task automatic put4(input logic [127:0] v);
    for (int i = 0; i < 4; i++) wr(16'h0420 + 16'(4 * i), v[127-32*i -: 32]);
  endtask : put4

  task automatic chk4(input logic [127:0] v);
    for (int i = 0; i < 4; i++) rdc(16'h0420 + 16'(4 * i), v[127-32*i -: 32]);
  endtask : chk4

  // Polls are bounded so a stuck flag ends as a mismatch, not a hang.
  task automatic poll(input logic [15:0] a, input int g, input logic w);
    logic [31:0] d;
    rd(a, d);
    for (int i = 0; i < 24 && d[g] !== w; i++) rd(a, d);
    check({31'h0, d[g]}, {31'h0, w});
  endtask : poll

  task automatic run_op(input logic [15:0] a, input logic [31:0] c,
                        input int g);
    wr(a, c);
    poll(a, g, 1'b0);
  endtask : run_op

  task automatic look(input logic [47:0] m, input logic [31:0] e);
    @(negedge core_clk);
    da_req = 1'b1;
    sa_req = 1'b1;
    mac = m;
    vlan_filter_group = 7'h12;
    @(negedge core_clk);
    da_req = 1'b0;
    sa_req = 1'b0;
    check({12'h0, da_valid, sa_valid, sa_drop, da_hit, da_static, da_drop,
           da_bypass, da_pri, da_spanning_group_id, da_fwd}, e);
  endtask : look

  // ========================================================================
  // Scenarios
  task automatic s_reset;
    chk4(128'h0);
    rdc(16'h0500, 32'h0);
  endtask : s_reset

  task automatic s_masks;
    put4({4{32'hFFFFFFFF}});
    chk4({`MTE_W1_MASK, `MTE_W2_MASK, `MTE_W3_MASK, `MTE_W4_MASK});
  endtask : s_masks

  task automatic s_static;
    put4(SW);
    run_op(`MTE_SCTRL_ADDR, 32'h0000008F, 7);
    poll(`MTE_SCTRL_ADDR, 8, 1'b1);
    put4(128'h0);
    run_op(`MTE_SCTRL_ADDR, 32'h000000AF, 7);
    chk4(SW);
  endtask : s_static

  // Same address as the static entry, so the static table must win.
  task automatic s_main;
    put4(MW);
    run_op(`MTE_MCTRL_ADDR, 32'h00009002, 15);
    poll(`MTE_SCTRL_ADDR, 8, 1'b0);
    put4(128'h0);
    run_op(`MTE_MCTRL_ADDR, 32'h0000A002, 15);
    poll(`MTE_MCTRL_ADDR, 16, 1'b1);
    chk4(MW);
    put4({32'h08000001, 96'h0});
    run_op(`MTE_MCTRL_ADDR, 32'h00009003, 15);
    run_op(`MTE_MCTRL_ADDR, 32'h0000A003, 15);
    poll(`MTE_MCTRL_ADDR, 16, 1'b0);
    chk4(128'h0);
    wr(`MTE_MCTRL_ADDR, 32'h0000B000);
    poll(`MTE_MCTRL_ADDR, 16, 1'b1);
    rdc(`MTE_ENTRY1_ADDR, MW[127:96]);
    rdc(`MTE_ENTRY4_ADDR, MW[31:0]);
    poll(`MTE_MCTRL_ADDR, 15, 1'b0);
  endtask : s_main

  task automatic s_lookup;
    @(negedge core_clk);
    age_tick = 1'b1;
    @(negedge core_clk);
    age_tick = 1'b0;
    look(48'hABCD01234567, 32'h000FF5D5);
    look(48'hABCD01234568, 32'h000C0000);
    // Clearing the valid flag hides the static entry; the main one answers.
    put4({32'h74000003, SW[95:0]});
    run_op(`MTE_SCTRL_ADDR, 32'h0000008F, 7);
    look(48'hABCD01234567, 32'h000F8883);
  endtask : s_lookup

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    #100000;
    bad_count++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    s_reset();
    s_masks();
    s_static();
    s_main();
    s_lookup();
    complete_run();
  end
endmodule : testbench
